/* File: src/hbp_core.sv */
// half-bridge pwm generator with dead time and an axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "hbp_params.svh"

// Overview of operation
// - period held 12-bit in two byte registers
// - cycle lasts period plus one prescaled clocks
// - duty buffered; active lasts duty plus one
// - counter readable, writes ignored
// - first output dead time is value plus one
// - first dead time clamped to duty
// - second output dead time is value plus one
// - second dead time clamped to period minus duty
// - maximum period limit writable, resets zero
// - minimum period limit writable, compared when adjusting
// - eight-bit period decrease step register
// - high byte upper bits read zero
// - adjust period each cycle until below minimum
// - each output inverted by its polarity bit
module hbp_core
  import hbp_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        PROT_ADJUST_I,
  output logic             FIRST_OUTPUT_O,
  output logic             SECOND_OUTPUT_O
);

  // software-visible buffer registers
  logic [11:0] period_value;
  logic [11:0] duty_value;
  logic [11:0] first_output_dead_time;
  logic [11:0] second_output_dead_time;
  logic [11:0] max_period_limit;
  logic [11:0] min_period_limit;
  logic [7:0]  period_decrease_step;
  logic [7:0]  ctrl;
  // working state
  hbp_cycle_t  act;
  hbp_state_t  state;
  logic [11:0] counter;
  logic [11:0] dt_cnt;
  logic [2:0]  psc;
  logic        tick;
  logic        boundary;
  // raw phases before dead time, then the registered gate levels
  logic        raw0;
  logic        raw1;
  logic        out0;
  logic        out1;
  // two-stage synchroniser for the protection request
  logic        prot_s1;
  logic        prot_s2;
  // decoded clock select field of the control word
  logic [1:0]  counter_clock_select;
  // axi bookkeeping
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_ok;

  // a byte lane write merges into a 12-bit value, high byte keeps four bits
  // the upper four bits of a high byte are dropped on the way in,
  // so they can never read back as anything but zero
  // one helper serves every split register, low and high halves alike
  function automatic logic [11:0] put_byte(input logic [11:0] cur, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b[3:0], cur[7:0]} : {cur[11:8], b};
  endfunction : put_byte

  // clamp a dead-time count to a limit
  // used for both outputs, each against the length of its own phase
  function automatic logic [11:0] clamp(input logic [11:0] v, input logic [11:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  // an offset is mapped when it is word aligned and not above status
  // anything else is answered with an error and reads as zero
  // shared by the write response and the read response
  function automatic logic decode_ok(input logic [7:0] a);
    decode_ok = (a <= `HBP_OFS_STAT) && (a[1:0] == 2'b00);
  endfunction : decode_ok

  // clock select picks the prescaler tap for the period counter
  assign counter_clock_select = ctrl[`HBP_CTRL_CKS_HI:`HBP_CTRL_CKS_LO];

  // write channel acceptance, address and data in either order
  // both readies stay low while a response stands, so a second write
  // cannot overwrite the held address or data before it is answered
  // the update happens one cycle after the later half is taken
  assign S_AXI_AWREADY_O = !aw_hold && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_hold && !S_AXI_BVALID_O;
  assign do_write        = aw_hold && w_hold && !S_AXI_BVALID_O;
  assign wr_ok           = decode_ok(aw_addr);

  // address half of a write, held until the register update
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_hold <= 1'b1;
      aw_addr <= S_AXI_AWADDR_I;
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  // data half of a write, held until the register update
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_hold <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  // write response, error for unmapped offsets
  // the response stands until the master shows bready
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= `HBP_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_ok ? `HBP_RESP_OKAY : `HBP_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // register writes; counter and status offsets take no write
  // only byte lane 0 carries data, the other lanes are ignored
  // a write to a running value lands in its buffer and waits for the
  // next period boundary before it reaches the outputs
  // split values are written one half at a time, so software should
  // finish both halves well before a boundary
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      period_value            <= {4'h0, `HBP_RST_BYTE};
      duty_value              <= {4'h0, `HBP_RST_BYTE};
      first_output_dead_time  <= {4'h0, `HBP_RST_BYTE};
      second_output_dead_time <= {4'h0, `HBP_RST_BYTE};
      max_period_limit        <= {4'h0, `HBP_RST_BYTE};
      min_period_limit        <= {4'h0, `HBP_RST_BYTE};
      period_decrease_step    <= `HBP_RST_BYTE;
      ctrl                    <= `HBP_RST_CTRL;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        `HBP_OFS_PER_LO:  period_value <= put_byte(period_value, 1'b0, w_data[7:0]);
        `HBP_OFS_PER_HI:  period_value <= put_byte(period_value, 1'b1, w_data[7:0]);
        `HBP_OFS_DUTY_LO: duty_value <= put_byte(duty_value, 1'b0, w_data[7:0]);
        `HBP_OFS_DUTY_HI: duty_value <= put_byte(duty_value, 1'b1, w_data[7:0]);
        `HBP_OFS_FDT_LO:  first_output_dead_time <=
                            put_byte(first_output_dead_time, 1'b0, w_data[7:0]);
        `HBP_OFS_FDT_HI:  first_output_dead_time <=
                            put_byte(first_output_dead_time, 1'b1, w_data[7:0]);
        `HBP_OFS_SDT_LO:  second_output_dead_time <=
                            put_byte(second_output_dead_time, 1'b0, w_data[7:0]);
        `HBP_OFS_SDT_HI:  second_output_dead_time <=
                            put_byte(second_output_dead_time, 1'b1, w_data[7:0]);
        `HBP_OFS_MAX_LO:  max_period_limit <= put_byte(max_period_limit, 1'b0, w_data[7:0]);
        `HBP_OFS_MAX_HI:  max_period_limit <= put_byte(max_period_limit, 1'b1, w_data[7:0]);
        `HBP_OFS_MIN_LO:  min_period_limit <= put_byte(min_period_limit, 1'b0, w_data[7:0]);
        `HBP_OFS_MIN_HI:  min_period_limit <= put_byte(min_period_limit, 1'b1, w_data[7:0]);
        `HBP_OFS_DEC:     period_decrease_step <= w_data[7:0];
        `HBP_OFS_CTRL:    ctrl <= w_data[7:0];
        default: begin
        end
      endcase
    end
  end

  // read channel; one read at a time, answered the cycle after acceptance
  // read data are registered, so they stand unchanged with rvalid
  // the counter is sampled when the address is taken, not when it is read
  // unmapped offsets return zero together with the error code
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= `HBP_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O  <= decode_ok(S_AXI_ARADDR_I) ? `HBP_RESP_OKAY : `HBP_RESP_SLVERR;
      case (S_AXI_ARADDR_I)
        `HBP_OFS_PER_LO:  S_AXI_RDATA_O <= {24'h0, period_value[7:0]};
        `HBP_OFS_PER_HI:  S_AXI_RDATA_O <= {28'h0, period_value[11:8]};
        `HBP_OFS_DUTY_LO: S_AXI_RDATA_O <= {24'h0, duty_value[7:0]};
        `HBP_OFS_DUTY_HI: S_AXI_RDATA_O <= {28'h0, duty_value[11:8]};
        `HBP_OFS_CNT_LO:  S_AXI_RDATA_O <= {24'h0, counter[7:0]};
        `HBP_OFS_CNT_HI:  S_AXI_RDATA_O <= {28'h0, counter[11:8]};
        `HBP_OFS_FDT_LO:  S_AXI_RDATA_O <= {24'h0, first_output_dead_time[7:0]};
        `HBP_OFS_FDT_HI:  S_AXI_RDATA_O <= {28'h0, first_output_dead_time[11:8]};
        `HBP_OFS_SDT_LO:  S_AXI_RDATA_O <= {24'h0, second_output_dead_time[7:0]};
        `HBP_OFS_SDT_HI:  S_AXI_RDATA_O <= {28'h0, second_output_dead_time[11:8]};
        `HBP_OFS_MAX_LO:  S_AXI_RDATA_O <= {24'h0, max_period_limit[7:0]};
        `HBP_OFS_MAX_HI:  S_AXI_RDATA_O <= {28'h0, max_period_limit[11:8]};
        `HBP_OFS_MIN_LO:  S_AXI_RDATA_O <= {24'h0, min_period_limit[7:0]};
        `HBP_OFS_MIN_HI:  S_AXI_RDATA_O <= {28'h0, min_period_limit[11:8]};
        `HBP_OFS_DEC:     S_AXI_RDATA_O <= {24'h0, period_decrease_step};
        `HBP_OFS_CTRL:    S_AXI_RDATA_O <= {24'h0, ctrl};
        `HBP_OFS_STAT:    S_AXI_RDATA_O <= {26'h0, act.period[11:8], 2'b00};
        default:          S_AXI_RDATA_O <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // prescaler: select divides the system clock by 1, 2, 4 or 8
  // it is cleared while disabled, so the first tick after enable
  // always comes at the same point of the divider
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !ctrl[`HBP_CTRL_EN]) begin
      psc <= 3'h0;
    end else begin
      psc <= psc + 3'h1;
    end
  end

  // one counter tick per selected number of system clocks
  always_comb begin
    case (counter_clock_select)
      2'b00:   tick = 1'b1;
      2'b01:   tick = psc[0];
      2'b10:   tick = &psc[1:0];
      default: tick = &psc;
    endcase
    tick = tick && ctrl[`HBP_CTRL_EN];
  end

  // the cycle ends on the tick at which the counter shows the period,
  // so one cycle lasts the period plus one ticks
  assign boundary = tick && (counter == act.period);

  // protection request from outside passes two flip-flops
  // the first stage may settle late; only the second stage is read
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      prot_s1 <= 1'b0;
      prot_s2 <= 1'b0;
    end else begin
      prot_s1 <= PROT_ADJUST_I;
      prot_s2 <= prot_s1;
    end
  end

  // period counter, 0..period inclusive
  // held at zero while disabled, so a restart opens with the first phase
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !ctrl[`HBP_CTRL_EN]) begin
      counter <= 12'h000;
    end else if (boundary) begin
      counter <= 12'h000;
    end else if (tick) begin
      counter <= counter + 12'h001;
    end
  end

  // active values and protection state change only at a boundary
  // the first load after enable comes at once because the active period
  // is still zero, so the outputs never run a full cycle of stale values
  // in adjust mode the period steps down by the decrease step once per
  // cycle; below the minimum it halts or holds, as the control word says
  // dropping the request returns to the buffered period one cycle later
  // halt is left only by clearing the enable bit
  // the maximum period register is kept for software and steers nothing
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !ctrl[`HBP_CTRL_EN]) begin
      act   <= '0;
      state <= HBP_RUN;
    end else if (boundary || (state == HBP_RUN && counter == 12'h000 && act.period == 12'h000)) begin
      act.duty <= duty_value;
      act.first_dt  <= first_output_dead_time;
      act.second_dt <= second_output_dead_time;
      case (state)
        HBP_RUN: begin
          act.period <= period_value;
          if (prot_s2 && ctrl[`HBP_CTRL_ADJ]) begin
            state <= HBP_ADJUST;
          end
        end
        HBP_ADJUST: begin
          if (act.period < min_period_limit) begin
            state <= ctrl[`HBP_CTRL_ADJ_SD] ? HBP_HALT : HBP_ADJUST;
          end else begin
            act.period <= act.period - {4'h0, period_decrease_step};
          end
          if (!prot_s2) begin
            state <= HBP_RUN;
          end
        end
        HBP_HALT: begin
          state <= HBP_HALT;
        end
        default: state <= HBP_RUN;
      endcase
    end
  end

  // dead-time counter restarts on each output phase change, counts system clocks
  // counting system clocks keeps the dead time apart from the prescaler
  // it saturates, so a long phase cannot wrap and reopen a closed gate
  // one counter serves both outputs, since their phases never overlap
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !ctrl[`HBP_CTRL_EN]) begin
      dt_cnt <= 12'h000;
    end else if (boundary || (tick && counter == act.duty)) begin
      dt_cnt <= 12'h000;
    end else if (dt_cnt != 12'hFFF) begin
      dt_cnt <= dt_cnt + 12'h001;
    end
  end

  // raw phases: first during 0..duty, second during the rest
  // the second phase is the exact complement, so the two never overlap
  assign raw0 = (counter <= act.duty);
  assign raw1 = !raw0;

  // each output waits its clamped dead time plus one clock after its phase opens
  // at clock select 00, a dead time as long as its phase keeps that output off for the whole
  // phase; halt and disable force both gates low
  // the gate levels are registered so the drivers see no decode glitches
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !ctrl[`HBP_CTRL_EN] || state == HBP_HALT) begin
      out0 <= 1'b0;
      out1 <= 1'b0;
    end else begin
      out0 <= raw0 && (dt_cnt > clamp(act.first_dt, act.duty));
      out1 <= raw1 && (dt_cnt > clamp(act.second_dt, act.period - act.duty));
    end
  end

  // polarity applied at the pins
  // a polarity change acts at once, not at the next boundary, so software
  // should change it only while the block is disabled
  assign FIRST_OUTPUT_O  = out0 ^ ctrl[`HBP_CTRL_INV0];
  assign SECOND_OUTPUT_O = out1 ^ ctrl[`HBP_CTRL_INV1];

endmodule : hbp_core
`default_nettype wire

/* File: shared/hbp_params.svh */
// register offsets, reset values and field positions of the half-bridge pwm core
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH
`define HBP_OFS_PER_LO    8'h00
`define HBP_OFS_PER_HI    8'h04
`define HBP_OFS_DUTY_LO   8'h08
`define HBP_OFS_DUTY_HI   8'h0C
`define HBP_OFS_CNT_LO    8'h10
`define HBP_OFS_CNT_HI    8'h14
`define HBP_OFS_FDT_LO    8'h18
`define HBP_OFS_FDT_HI    8'h1C
`define HBP_OFS_SDT_LO    8'h20
`define HBP_OFS_SDT_HI    8'h24
`define HBP_OFS_MAX_LO    8'h28
`define HBP_OFS_MAX_HI    8'h2C
`define HBP_OFS_MIN_LO    8'h30
`define HBP_OFS_MIN_HI    8'h34
`define HBP_OFS_DEC       8'h38
`define HBP_OFS_CTRL      8'h3C
`define HBP_OFS_STAT      8'h40
`define HBP_RST_BYTE      8'h00
`define HBP_RST_CTRL      8'h00
`define HBP_CTRL_EN       0
`define HBP_CTRL_CKS_LO   1
`define HBP_CTRL_CKS_HI   2
`define HBP_CTRL_INV0     3
`define HBP_CTRL_INV1     4
`define HBP_CTRL_ADJ      5
`define HBP_CTRL_ADJ_SD   6
`define HBP_RESP_OKAY     2'b00
`define HBP_RESP_SLVERR   2'b10
`endif

/* File: shared/hbp_pkg.sv */
// types shared by the half-bridge pwm core
`default_nettype none
package hbp_pkg;
  typedef struct packed {
    logic [11:0] period;
    logic [11:0] duty;
    logic [11:0] first_dt;
    logic [11:0] second_dt;
  } hbp_cycle_t;
  typedef enum logic [1:0] {
    HBP_RUN,
    HBP_ADJUST,
    HBP_HALT
  } hbp_state_t;
endpackage : hbp_pkg
`default_nettype wire

/* File: test/hbp_core_properties.sv */
// bus-handshake and register-width checks on the pwm core ports
`timescale 1ns/10ps
`default_nettype none
module hbp_core_chk (
  input wire logic        MCLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // write answer two cycles after both halves are taken, read answer one
  chk_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> ##1 S_AXI_BVALID_O) else $error("write answer missing");
  chk_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("read answer missing");
  // answers stand until accepted; the write answer then drops
  chk_bvalid_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O) else $error("write answer dropped early");
  chk_rdata_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data moved");
  chk_bvalid_drop: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
    |=> !S_AXI_BVALID_O) else $error("write answer stuck");
  // no new request taken while an answer stands
  chk_no_aw_busy: assert property (S_AXI_BVALID_O
    |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write taken while busy");
  chk_no_ar_busy: assert property (S_AXI_RVALID_O
    |-> !S_AXI_ARREADY_O) else $error("read taken while busy");
  // every register is one byte wide
  chk_byte_width: assert property (S_AXI_RVALID_O
    |-> S_AXI_RDATA_O[31:8] == 24'h000000) else $error("read data above byte");
endmodule : hbp_core_chk
bind hbp_core hbp_core_chk u_chk (.*);
`default_nettype wire

/* File: test/hbp_gate_model.sv */
// gate driver pair model: on-time counters and shoot-through flag
`timescale 1ns/10ps
`default_nettype none
module hbp_gate_model (
  input  wire logic clk_i,
  input  wire logic clr_i,
  input  wire logic hi_i,
  input  wire logic lo_i,
  output int        hi_on_o,
  output int        lo_on_o,
  output logic      shoot_o
);
  // count switch on-time and latch any overlap of the two gates
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      hi_on_o <= 0;
      lo_on_o <= 0;
      shoot_o <= 1'b0;
    end else begin
      hi_on_o <= hi_on_o + int'(hi_i);
      lo_on_o <= lo_on_o + int'(lo_i);
      shoot_o <= shoot_o | (hi_i & lo_i);
    end
  end
endmodule : hbp_gate_model
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the half-bridge pwm core
`timescale 1ns/10ps
`default_nettype none
`include "hbp_params.svh"
module tb_top;
  logic        clk, rst, awv, wv, bry, arv, rry, prot, clr, awr, wr_, bv, arr, rv, o0, o1, sh;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  br, rr;
  int          h, l, errors, samples_checked;

  hbp_core dut (.MCLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .PROT_ADJUST_I(prot),
    .FIRST_OUTPUT_O(o0), .SECOND_OUTPUT_O(o1));
  hbp_gate_model gm (.clk_i(clk), .clr_i(clr), .hi_i(o0), .lo_i(o1), .hi_on_o(h),
    .lo_on_o(l), .shoot_o(sh));

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int   n;
    logic ta, tw, done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!done && n < 100) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr_;
      done = bv;
      if (done) chk({30'h0, br}, {30'h0, e});
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (done) bry <= 1'b0;
      n++;
    end
    if (!done) errors++;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int   n;
    logic ta, done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    while (!done && n < 100) begin
      @(negedge clk);
      ta = arv && arr;
      done = rv;
      if (done) chk(rd, e);
      if (done) chk({30'h0, rr}, {30'h0, er});
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (done) rry <= 1'b0;
      n++;
    end
    if (!done) errors++;
  endtask : rdc

  // program period, duty, both dead times and control, then let it settle
  task automatic cfg(input logic [11:0] p, du, d0, d1, input logic [7:0] c);
    wr(`HBP_OFS_PER_LO, {24'h0, p[7:0]}, 2'b00);
    wr(`HBP_OFS_PER_HI, {28'h0, p[11:8]}, 2'b00);
    wr(`HBP_OFS_DUTY_LO, {24'h0, du[7:0]}, 2'b00);
    wr(`HBP_OFS_DUTY_HI, {28'h0, du[11:8]}, 2'b00);
    wr(`HBP_OFS_FDT_LO, {24'h0, d0[7:0]}, 2'b00);
    wr(`HBP_OFS_FDT_HI, {28'h0, d0[11:8]}, 2'b00);
    wr(`HBP_OFS_SDT_LO, {24'h0, d1[7:0]}, 2'b00);
    wr(`HBP_OFS_SDT_HI, {28'h0, d1[11:8]}, 2'b00);
    wr(`HBP_OFS_CTRL, {24'h0, c}, 2'b00);
    repeat (100) @(posedge clk);
  endtask : cfg

  // on-time of each gate over a window of whole pwm cycles
  task automatic win(input int n, input int eh, input int el, input logic es);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk(32'(h), 32'(eh));
    chk(32'(l), 32'(el));
    chk({31'h0, sh}, {31'h0, es});
  endtask : win

  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  // main sequence: registers first, then waveforms
  initial begin
    {awv, wv, bry, arv, rry, prot, clr} = '0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 15; i++) rdc(8'(4 * i), 32'h0, 2'b00);
    for (int i = 0; i < 15; i++) wr(8'(4 * i), 32'hFFFFFFFF, 2'b00);
    for (int i = 0; i < 15; i++) rdc(8'(4 * i), (i == 4 || i == 5) ? 32'h0 :
      (i % 2 == 1 && i < 14) ? 32'h0F : 32'hFF, 2'b00);
    rdc(8'h44, 32'h0, 2'b10);
    rdc(8'h01, 32'h0, 2'b10);
    wr(8'h48, 32'h1, 2'b10);
    rdc(`HBP_OFS_STAT, 32'h0, 2'b00);
    wr(`HBP_OFS_MIN_LO, 32'h08, 2'b00);
    wr(`HBP_OFS_MIN_HI, 32'h00, 2'b00);
    wr(`HBP_OFS_DEC, 32'h04, 2'b00);
    cfg(12'd19, 12'd4, 12'd1, 12'd1, 8'h01);
    win(40, 6, 26, 1'b0);
    cfg(12'd19, 12'd4, 12'hFFF, 12'd1, 8'h01);
    win(40, 0, 26, 1'b0);
    cfg(12'd19, 12'd4, 12'd1, 12'hFFF, 8'h01);
    win(40, 6, 0, 1'b0);
    cfg(12'd19, 12'd4, 12'd1, 12'd1, 8'h03);
    win(80, 16, 56, 1'b0);
    cfg(12'd19, 12'd4, 12'd1, 12'd1, 8'h09);
    win(40, 34, 26, 1'b1);
    cfg(12'd19, 12'd4, 12'd1, 12'd1, 8'h21);
    prot <= 1'b1;
    repeat (200) @(posedge clk);
    win(40, 15, 5, 1'b0);
    @(posedge clk);
    prot <= 1'b0;
    repeat (100) @(posedge clk);
    win(40, 6, 26, 1'b0);
    rdc(`HBP_OFS_CTRL, 32'h21, 2'b00);
    cfg(12'd19, 12'd4, 12'd1, 12'd1, 8'h61);
    prot <= 1'b1;
    repeat (200) @(posedge clk);
    win(40, 0, 0, 1'b0);
    @(posedge clk);
    prot <= 1'b0;
    repeat (100) @(posedge clk);
    win(40, 0, 0, 1'b0);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
